// ==== logic/tout_pkg.sv ====
// Constants for the timer channel output control block
package tout_pkg;
   localparam int NUM_CH = 8;
   localparam logic [11:0] OFF_LEVEL    = 12'h000;
   localparam logic [11:0] OFF_ENABLE   = 12'h004;
   localparam logic [11:0] OFF_POLARITY = 12'h008;
   localparam logic [11:0] OFF_MODE     = 12'h00c;
   localparam logic [11:0] OFF_OPTION   = 12'h010;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
   localparam logic [15:0] LEVEL_RST    = 16'h0000;
   localparam logic [15:0] ENABLE_RST   = 16'h0000;
   localparam logic [7:0]  CFG_RST      = 8'h00;
   localparam int SET_DELAY_CYCLES = 1;
   typedef enum logic [1:0] {
      CM_INTERVAL, CM_CAPTURE, CM_EVENT, CM_ONE_COUNT
   } count_mode_t;
endpackage

// ==== logic/timer_channel_output_control.sv ====
// Output pin control for an eight-channel timer unit
// Functional notes
// - Master mode: toggle on own interrupt when enabled, polarity ignored.
// - Slave mode: master sets active, slave resets; polarity picks active level.
// - Coincident set and reset: reset wins, giving zero duty.
// - Output enable 1 discards software writes; only interrupts change pin.
// - Output enable 0 accepts writes and blocks interrupts.
// - Output register readable anytime, returns pin level.
// - Polarity change applies at the next set or reset, not immediately.
// - Master set is delayed one count clock in slave logic.
// - Register write updates only bits whose enable is 0.
// - Interval or capture with start option 1: interrupt and toggle at start.
// - Start option 0: no start interrupt; first after full count cycle.
// - Other modes never produce a start interrupt or action.
// - Output writes never disturb counter or data registers.
// - Channels 0 to 7; masters 0,2,4,6; slave above master.
// - Enable or polarity change coincident with interrupt is order dependent.
//
// Chosen here: register access over APB and the register addresses.
module timer_channel_output_control
   import tout_pkg::*;
#(
   parameter int N = NUM_CH
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [N-1:0]      channel_interrupt,
   input  wire logic [N-1:0]      channel_start_trigger,
   input  wire logic [2*N-1:0]    channel_mode,
   output logic      [N-1:0]      channel_output_bit,
   output logic      [N-1:0]      start_interrupt,
   output logic                   irq
);
   logic [N-1:0] level_reg, enable_reg, polarity_reg, mode_reg, option_reg;
   logic [N-1:0] irq_stat_reg, irq_mask_reg;
   logic [N-1:0] set_dly_reg, master_int, slave_int, start_ev, ev;
   logic [N-1:0] level_next;
   logic [N-1:0] irq_clr;
   logic         wr, rd, hit;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign hit = (paddr == OFF_LEVEL) || (paddr == OFF_ENABLE) ||
                (paddr == OFF_POLARITY) || (paddr == OFF_MODE) ||
                (paddr == OFF_OPTION) || (paddr == OFF_IRQ_STAT) ||
                (paddr == OFF_IRQ_MASK);

   // Start trigger events; only interval and capture modes qualify
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_ch
         count_mode_t cm;
         assign cm = count_mode_t'(channel_mode[2*g +: 2]);
         assign start_ev[g] = channel_start_trigger[g] && option_reg[g] &&
                              (cm == CM_INTERVAL || cm == CM_CAPTURE);
         assign ev[g] = channel_interrupt[g] | start_ev[g];
         // master is nearest lower even channel
         if (g % 2 == 0) begin : gen_m
            assign master_int[g] = 1'b0;
         end else begin : gen_s
            assign master_int[g] = ev[g - 1];
         end
         assign slave_int[g] = ev[g];
      end
   endgenerate

   // set delayed, masked by coincident reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         set_dly_reg <= '0;
      end else begin
         set_dly_reg <= master_int & ~slave_int;
      end
   end

   always_comb begin
      level_next = level_reg;
      for (int i = 0; i < N; i++) begin
         // old enable and polarity apply at an event edge
         if (enable_reg[i]) begin
            if (!mode_reg[i]) begin
               if (ev[i]) begin
                  level_next[i] = ~level_reg[i];
               end
            end else if (slave_int[i]) begin
               level_next[i] = polarity_reg[i];
            end else if (set_dly_reg[i]) begin
               level_next[i] = ~polarity_reg[i];
            end
         end else if (wr && paddr == OFF_LEVEL) begin
            level_next[i] = pwdata[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         level_reg  <= LEVEL_RST[N-1:0];
         enable_reg <= ENABLE_RST[N-1:0];
      end else begin
         level_reg <= level_next;
         if (wr && paddr == OFF_ENABLE) begin
            enable_reg <= pwdata[N-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         polarity_reg   <= CFG_RST[N-1:0];
         mode_reg       <= CFG_RST[N-1:0];
         option_reg     <= CFG_RST[N-1:0];
         irq_mask_reg   <= CFG_RST[N-1:0];
      end else if (wr) begin
         if (paddr == OFF_POLARITY) begin
            polarity_reg <= pwdata[N-1:0];
         end else if (paddr == OFF_MODE) begin
            mode_reg <= pwdata[N-1:0];
         end else if (paddr == OFF_OPTION) begin
            option_reg <= pwdata[N-1:0];
         end else if (paddr == OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[N-1:0];
         end
      end
   end

   // Set wins over write-one clear
   assign irq_clr = (wr && paddr == OFF_IRQ_STAT) ? pwdata[N-1:0] : '0;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
         irq          <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | start_ev;
         irq          <= |(((irq_stat_reg & ~irq_clr) | start_ev) &
                           irq_mask_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         channel_output_bit <= '0;
         start_interrupt    <= '0;
      end else begin
         channel_output_bit <= level_next;
         start_interrupt    <= start_ev;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata  <= '0;
         if (rd) begin
            if (paddr == OFF_LEVEL) begin
               prdata[N-1:0] <= level_reg;
            end else if (paddr == OFF_ENABLE) begin
               prdata[N-1:0] <= enable_reg;
            end else if (paddr == OFF_POLARITY) begin
               prdata[N-1:0] <= polarity_reg;
            end else if (paddr == OFF_MODE) begin
               prdata[N-1:0] <= mode_reg;
            end else if (paddr == OFF_OPTION) begin
               prdata[N-1:0] <= option_reg;
            end else if (paddr == OFF_IRQ_STAT) begin
               prdata[N-1:0] <= irq_stat_reg;
            end else if (paddr == OFF_IRQ_MASK) begin
               prdata[N-1:0] <= irq_mask_reg;
            end
         end
      end
   end
endmodule

// ==== tb/pin_load.sv ====
// Load model hanging on the timer output pins
module pin_load (
   input  wire logic [7:0] pin,
   input  wire logic       clk,
   output logic      [7:0] sensed
);
   timeunit 1ns;
   timeprecision 1ps;
   // Push-pull pins, so the load only follows them
   always_ff @(posedge clk) sensed <= pin;
endmodule

// ==== tb/tout_sva.sv ====
// Port-level checker for the timer output control block
module tout_sva
   import tout_pkg::*;
#(parameter int N = NUM_CH) (
   input wire logic           clk,
   input wire logic           rst_n,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [11:0]    paddr,
   input wire logic [31:0]    pwdata,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   input wire logic [N-1:0]   channel_interrupt,
   input wire logic [N-1:0]   channel_start_trigger,
   input wire logic [2*N-1:0] channel_mode,
   input wire logic [N-1:0]   channel_output_bit,
   input wire logic [N-1:0]   start_interrupt,
   input wire logic           irq
);
   logic [N-1:0] en, md, pol, opt;
   wire          wr = psel && penable && pwrite && pready;
   wire [N-1:0]  ci = channel_interrupt;
   wire [N-1:0]  o  = channel_output_bit;
   wire          st = channel_start_trigger[0];
   wire          ok = !channel_mode[1];
   // Shadows, since the checker sees no internal register
   always_ff @(posedge clk) begin
      if (!rst_n) {en, md, pol, opt} <= '0;
      else if (wr && paddr == OFF_ENABLE) en <= pwdata[N-1:0];
      else if (wr && paddr == OFF_MODE) md <= pwdata[N-1:0];
      else if (wr && paddr == OFF_POLARITY) pol <= pwdata[N-1:0];
      else if (wr && paddr == OFF_OPTION) opt <= pwdata[N-1:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   rd_level_a: assert property (pready && !pwrite && paddr == OFF_LEVEL
      |-> prdata[N-1:0] == o) else $error("level read mismatch");
   toggle_a: assert property (en[0] && !md[0] && ci[0]
      |=> o[0] != $past(o[0])) else $error("no toggle");
   no_fwd_a: assert property (!en[0] && !(wr && paddr == OFF_LEVEL)
      |=> $stable(o[0])) else $error("disabled pin moved");
   slv_reset_a: assert property (en[1] && md[1] && ci[1]
      |=> o[1] == pol[1]) else $error("reset lost");
   set_delay_a: assert property (en[1] && md[1] && ci[0] && !ci[1]
      && !$past(ci[0]) |=> $stable(o[1]) ##1 o[1] == (pol[1] ^ !$past(ci[1])))
      else $error("set timing wrong");
   pol_hold_a: assert property (wr && paddr == OFF_POLARITY && ci == '0
      && $past(ci) == '0 && !st |=> o == $past(o)) else $error("pol moved");
   lvl_mask_a: assert property (wr && paddr == OFF_LEVEL
      |=> (o & ~en) == ($past(pwdata[N-1:0]) & ~en)) else $error("mask");
   start_on_a: assert property (st && opt[0] && ok
      |=> start_interrupt[0]) else $error("start irq missing");
   start_off_a: assert property (st && !(opt[0] && ok)
      |=> !start_interrupt[0]) else $error("start irq stray");
   cover property (en[1] && md[1] && ci[0] && ci[1]);
   cover property (wr && paddr == OFF_LEVEL && en != '0);
   cover property (start_interrupt[0]);
endmodule
bind timer_channel_output_control tout_sva #(.N(N)) chk (.*);

// ==== tb/timer_channel_output_control_tb_top.sv ====
// Self-checking bench for the timer output control block
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module timer_channel_output_control_tb_top import tout_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  ci, st, o, si, sensed;
   logic [15:0] cm;
   int          failures = 0, checked = 0;
   logic [11:0] ra[5] = '{OFF_LEVEL, OFF_LEVEL, OFF_ENABLE, OFF_LEVEL,
                          OFF_ENABLE};
   logic [7:0]  rw[5] = '{8'h5a, 8'ha5, 8'h0f, 8'hff, 8'h00};
   logic [7:0]  rx[5] = '{8'h5a, 8'ha5, 8'h0f, 8'hf5, 8'h00};
   timer_channel_output_control dut (.clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .channel_interrupt(ci),
      .channel_start_trigger(st), .channel_mode(cm), .channel_output_bit(o),
      .start_interrupt(si), .irq);
   pin_load load (.pin(o), .clk, .sensed);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic pulse(input logic [7:0] i, input logic [7:0] s);
      @(posedge clk);
      {ci, st} <= {i, s};
      @(posedge clk);
      {ci, st} <= 16'h0000;
      #1;
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, ci, st, cm} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1;
      #1;
      `CHK(o, 8'h00)
      foreach (ra[i]) begin
         apb(1, ra[i], {24'h0, rw[i]});
         apb(0, ra[i], 0);
         `CHK(rd[7:0], rx[i])
      end
      $display("register rows done");
      apb(1, OFF_ENABLE, 1);
      pulse(8'h03, 0);
      `CHK(o, 8'hf4)
      apb(1, OFF_MODE, 2);
      apb(1, OFF_LEVEL, 0);
      apb(1, OFF_ENABLE, 3);
      pulse(8'h01, 0);
      `CHK(o[1], 1'b0)
      tick();
      `CHK(o[1], 1'b1)
      pulse(8'h03, 0);
      tick();
      `CHK(o[1], 1'b0)
      apb(1, OFF_POLARITY, 2);
      #1;
      `CHK(o[1], 1'b0)
      pulse(8'h02, 0);
      `CHK(o[1], 1'b1)
      apb(1, OFF_LEVEL, 0);
      `CHK(o[1:0], 2'b10)
      $display("output modes done");
      apb(1, OFF_OPTION, 1);
      apb(1, OFF_IRQ_MASK, 1);
      pulse(0, 1);
      `CHK(si[0], 1'b1)
      tick();
      tick();
      `CHK(o[0], 1'b1)
      `CHK(irq, 1'b1)
      apb(1, OFF_IRQ_MASK, 0);
      tick();
      `CHK(irq, 1'b0)
      apb(1, OFF_IRQ_MASK, 1);
      tick();
      `CHK(irq, 1'b1)
      apb(1, OFF_IRQ_STAT, 1);
      tick();
      `CHK(irq, 1'b0)
      cm <= 16'h0002;
      pulse(0, 1);
      `CHK(si[0], 1'b0)
      apb(1, OFF_OPTION, 0);
      cm <= 16'h0000;
      pulse(0, 1);
      `CHK(si[0], 1'b0)
      apb(0, 12'h01c, 0);
      `CHK(err, 1'b1)
      `CHK(sensed, o)
      $display("start and irq done");
      summarize();
   end
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule
